/* see_pkg.sv */
/*
  Shared constants of the two-wire serial memory link: device address
  layout, memory geometry, timing counts and controller register map.
  Assumes a 10 MHz system clock on both ends.
*/
package see_pkg;
  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int          CLK_NS       = 100;
  localparam int          T_WR_US      = 10000;
  localparam int          PROG_CYCLES  = (T_WR_US * 1000) / CLK_NS;
  localparam logic [7:0]  QUARTER_RST  = 8'h05;

  // ------------------------------------------------------------------
  // device address word and memory geometry
  // ------------------------------------------------------------------
  // type prefix value is arbitrary
  localparam logic [4:0]  TYPE_PREFIX  = 5'h0B;
  localparam int          PREFIX_MSB   = 7;
  localparam int          PREFIX_LSB   = 3;
  localparam int          CS_BIT       = 2;
  localparam int          PAGE_BIT     = 1;
  localparam int          RW_BIT       = 0;
  localparam int          ADDR_W       = 17;
  localparam int          MEM_DEPTH    = 131072;
  localparam int          PAGE_SIZE    = 256;
  localparam logic [3:0]  BITS_BYTE    = 4'h8;

  // ------------------------------------------------------------------
  // controller registers (byte addresses) and fields
  // ------------------------------------------------------------------
  localparam logic [7:0]  REG_CMD      = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_DIV      = 8'h08;
  localparam int          CMD_START    = 8;
  localparam int          CMD_STOP     = 9;
  localparam int          CMD_READ     = 10;
  localparam int          CMD_ACK      = 11;
  localparam int          CMD_NOBYTE   = 12;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_NACK      = 1;
  localparam int          ST_RX_LSB    = 8;
endpackage

/* see_link_if.sv */
/*
  Two-wire link between controller and memory device.
  Assumes an external pull-up on the data line; the bench drives the
  write-protect and strap signals directly.
*/
`timescale 1ns/1ps
interface see_link_if;
  logic scl;          // serial clock, made by the controller
  logic sda;          // resolved open-drain data line
  logic dev_sda_out;  // device data output
  logic dev_sda_oe;   // device drives the data line
  logic ctl_sda_out;  // controller data output
  logic ctl_sda_oe;   // controller drives the data line
  logic wp;           // write protect level
  logic cs_level;     // strap level when connected
  logic cs_connected; // strap pin is wired

  // wired-and with pull-up: any enabled low driver wins
  assign sda = ~((dev_sda_oe & ~dev_sda_out) | (ctl_sda_oe & ~ctl_sda_out));

  modport dev (input scl, input sda, input wp, input cs_level, input cs_connected,
               output dev_sda_out, output dev_sda_oe);
  modport ctl (output scl, output ctl_sda_out, output ctl_sda_oe, input sda);
endinterface

/* see_dev.sv */
/*
  Serial memory device end: 131072 bytes, page write buffer, self-timed
  program cycle, current/random/sequential reads.
  Assumes link pins arrive asynchronously and are synchronised here;
  the link clock must stay well below a quarter of pclk.
*/
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module see_dev #(
  parameter int PROG_CYCLES = see_pkg::PROG_CYCLES
) (
  input  wire logic pclk,    // system clock
  input  wire logic presetn, // async reset, active low
  see_link_if.dev   link,    // two-wire link
  output logic      busy     // program cycle running
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    D_IDLE, D_DEV, D_ADDRH, D_ADDRL, D_WDATA, D_RDATA, D_RACK, D_PROG
  } see_dst_t;

  typedef struct packed {
    see_dst_t            st;
    logic [3:0]          cnt;
    logic [7:0]          sh;
    logic                ack;
    logic                more;
    logic                wrote;
    logic [16:0]         addr;
    logic [7:0]          ah;
    logic [8:0]          page;
    logic                scl1, scl2, scl3;
    logic                sda1, sda2, sda3;
    logic                wp1, wp2;
    logic                csl1, csl2, csc1, csc2;
    logic [23:0]         tmr;
    logic [8:0]          cidx;
    logic                oe;
    logic                busy;
  } see_dev_t;

  see_dev_t   r;
  see_dev_t   next_r;
  logic [7:0] mem [see_pkg::MEM_DEPTH];
  logic [7:0] pbuf [see_pkg::PAGE_SIZE];
  logic [255:0] valid;
  logic       buf_we;
  logic       mem_we;
  logic       vclr;
  logic [7:0] rbyte;
  logic       rise, fall, start, stop, cs_eff, match;

  assign rbyte = mem[r.addr];
  assign rise  = r.scl2 & ~r.scl3;
  assign fall  = ~r.scl2 & r.scl3;
  assign start = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
  assign stop  = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
  assign cs_eff = r.csc2 & r.csl2;
  assign match = (r.sh[see_pkg::PREFIX_MSB:see_pkg::PREFIX_LSB] == see_pkg::TYPE_PREFIX)
               & (r.sh[see_pkg::CS_BIT] == cs_eff);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_r      = r;
    buf_we      = 1'b0;
    mem_we      = 1'b0;
    vclr        = 1'b0;
    next_r.scl1 = link.scl;
    next_r.scl2 = r.scl1;
    next_r.scl3 = r.scl2;
    next_r.sda1 = link.sda;
    next_r.sda2 = r.sda1;
    next_r.sda3 = r.sda2;
    next_r.wp1  = link.wp;
    next_r.wp2  = r.wp1;
    next_r.csl1 = link.cs_level;
    next_r.csl2 = r.csl1;
    next_r.csc1 = link.cs_connected;
    next_r.csc2 = r.csc1;
    if (r.st == D_PROG) begin
      if (!r.cidx[8]) begin
        mem_we      = valid[r.cidx[7:0]];
        next_r.cidx = r.cidx + 9'h001;
      end
      if (r.tmr >= 24'(PROG_CYCLES - 1) && r.cidx[8]) begin
        vclr        = 1'b1;
        next_r.st   = D_IDLE;
        next_r.busy = 1'b0;
      end else begin
        next_r.tmr = r.tmr + 24'h000001;
      end
    end else if (start) begin
      next_r.st    = D_DEV;
      next_r.cnt   = 4'h0;
      next_r.ack   = 1'b0;
      next_r.oe    = 1'b0;
      next_r.wrote = 1'b0;
      vclr         = 1'b1;
    end else if (stop) begin
      next_r.oe  = 1'b0;
      next_r.ack = 1'b0;
      if (r.wrote && !r.wp2) begin
        next_r.st   = D_PROG;
        next_r.tmr  = 24'h000000;
        next_r.cidx = 9'h000;
        next_r.busy = 1'b1;
      end else begin
        next_r.st = D_IDLE;
        vclr      = 1'b1;
      end
    end else begin
      case (r.st)
        D_DEV, D_ADDRH, D_ADDRL, D_WDATA: begin
          if (rise && !r.ack) begin
            next_r.sh  = {r.sh[6:0], r.sda2};
            next_r.cnt = r.cnt + 4'h1;
          end else if (fall && r.ack) begin
            next_r.ack = 1'b0;
            next_r.oe  = 1'b0;
            next_r.cnt = 4'h0;
            case (r.st)
              D_DEV: begin
                if (r.sh[see_pkg::RW_BIT]) begin
                  next_r.st = D_RDATA;
                  next_r.sh = rbyte;
                  next_r.oe = ~rbyte[7];
                end else begin
                  next_r.st = D_ADDRH;
                end
              end
              D_ADDRH: next_r.st = D_ADDRL;
              default: next_r.st = D_WDATA;
            endcase
          end else if (fall && r.cnt == see_pkg::BITS_BYTE) begin
            next_r.ack = 1'b1;
            next_r.oe  = 1'b1;
            case (r.st)
              D_DEV: begin
                if (!match) begin
                  next_r.st  = D_IDLE;
                  next_r.ack = 1'b0;
                  next_r.oe  = 1'b0;
                end
              end
              D_ADDRH: next_r.ah = r.sh;
              D_ADDRL: begin
                next_r.addr = {r.page[8], r.ah, r.sh};
                next_r.page = {r.page[8], r.ah};
              end
              default: begin
                buf_we       = 1'b1;
                next_r.wrote = 1'b1;
                next_r.addr  = {r.addr[16:8], r.addr[7:0] + 8'h01};
              end
            endcase
            if (r.st == D_DEV) begin
              next_r.page[8] = r.sh[see_pkg::PAGE_BIT];
            end
          end
        end
        D_RDATA: begin
          if (rise) begin
            next_r.cnt = r.cnt + 4'h1;
          end else if (fall) begin
            if (r.cnt == see_pkg::BITS_BYTE) begin
              next_r.oe   = 1'b0;
              next_r.st   = D_RACK;
              next_r.more = 1'b0;
              next_r.addr = r.addr + 17'h00001;
            end else begin
              next_r.oe = ~r.sh[6];
              next_r.sh = {r.sh[6:0], 1'b0};
            end
          end
        end
        D_RACK: begin
          if (rise) begin
            next_r.more = ~r.sda2;
          end else if (fall) begin
            if (r.more) begin
              next_r.st  = D_RDATA;
              next_r.cnt = 4'h0;
              next_r.sh  = rbyte;
              next_r.oe  = ~rbyte[7];
            end else begin
              next_r.st = D_IDLE;
            end
          end
        end
        default: next_r.oe = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers and storage
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // memory content survives reset, as it would survive power loss
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[{r.page, r.cidx[7:0]}] <= pbuf[r.cidx[7:0]];
    end
    if (buf_we) begin
      pbuf[r.addr[7:0]] <= r.sh;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= '0;
    end else if (vclr) begin
      valid <= '0;
    end else if (buf_we) begin
      valid[r.addr[7:0]] <= 1'b1;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe  = r.oe;
  assign busy             = r.busy;
endmodule

/* see_ctl.sv */
/*
  Two-wire bus controller driven over APB. Each command issues an
  optional start, one byte unless CMD_NOBYTE is set (sent or received with its acknowledge)
  and a stop when CMD_STOP is set or when CMD_NOBYTE is set without CMD_START. Assumes the device end on the same link.
*/
`timescale 1ns/1ps
module see_ctl (
  input  wire logic        pclk,    // system clock
  input  wire logic        presetn, // async reset, active low
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb access phase
  input  wire logic        pwrite,  // apb write
  input  wire logic [7:0]  paddr,   // apb byte address
  input  wire logic [31:0] pwdata,  // apb write data
  output logic      [31:0] prdata,  // apb read data
  output logic             pready,  // apb ready
  output logic             pslverr, // apb error, unmapped address
  see_link_if.ctl          link     // two-wire link
);
  typedef enum logic [1:0] {C_IDLE, C_START, C_BITS, C_STOP} see_cst_t;

  typedef struct packed {
    see_cst_t    st;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [12:0] cmd;
    logic [7:0]  rx;
    logic        nack;
    logic        busy;
    logic        scl;
    logic        oe;
    logic [7:0]  quarter;
    logic [7:0]  dcnt;
    logic        s1, s2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } see_ctl_t;

  see_ctl_t r;
  see_ctl_t next_r;
  logic     tick;
  logic     wr;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == see_pkg::REG_CMD) || (a == see_pkg::REG_STATUS) || (a == see_pkg::REG_DIV);
  endfunction

  assign tick = (r.dcnt == r.quarter);
  assign wr   = psel & penable & r.pready & pwrite;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.s1      = link.sda;
    next_r.s2      = r.s1;
    next_r.pready  = psel & ~penable;
    next_r.pslverr = psel & ~penable & ~mapped(paddr);
    next_r.dcnt    = tick ? 8'h00 : r.dcnt + 8'h01;
    if (psel && !penable) begin
      if (paddr == see_pkg::REG_STATUS) begin
        next_r.prdata = {16'h0000, r.rx, 6'h00, r.nack, r.busy};
      end else if (paddr == see_pkg::REG_DIV) begin
        next_r.prdata = {24'h000000, r.quarter};
      end else if (paddr == see_pkg::REG_CMD) begin
        next_r.prdata = {19'h00000, r.cmd};
      end else begin
        next_r.prdata = 32'h00000000;
      end
    end
    if (wr && paddr == see_pkg::REG_DIV) begin
      next_r.quarter = pwdata[7:0];
    end
    // commands while busy are dropped
    if (wr && paddr == see_pkg::REG_CMD && !r.busy) begin
      next_r.cmd  = pwdata[12:0];
      next_r.busy = 1'b1;
      next_r.ph   = 2'h0;
      next_r.bitn = 4'h0;
      next_r.dcnt = 8'h00;
      if (pwdata[see_pkg::CMD_START]) begin
        next_r.st = C_START;
      end else if (pwdata[see_pkg::CMD_NOBYTE]) begin
        next_r.st = C_STOP;
      end else begin
        next_r.st = C_BITS;
      end
    end else if (tick && r.st != C_IDLE) begin
      next_r.ph = r.ph + 2'h1;
      case (r.st)
        C_START: begin
          case (r.ph)
            2'h0: next_r.oe  = 1'b0;
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.oe  = 1'b1;
            default: begin
              next_r.scl = 1'b0;
              if (!r.cmd[see_pkg::CMD_NOBYTE]) begin
                next_r.st = C_BITS;
              end else if (r.cmd[see_pkg::CMD_STOP]) begin
                next_r.st = C_STOP;
              end else begin
                next_r.st   = C_IDLE;
                next_r.busy = 1'b0;
              end
            end
          endcase
        end
        C_BITS: begin
          case (r.ph)
            2'h0: begin
              // change data only with clock low
              if (r.bitn < see_pkg::BITS_BYTE) begin
                next_r.oe = ~r.cmd[see_pkg::CMD_READ] & ~r.cmd[4'd7 - r.bitn[2:0]];
              end else begin
                next_r.oe = r.cmd[see_pkg::CMD_READ] & r.cmd[see_pkg::CMD_ACK];
              end
            end
            2'h1: next_r.scl = 1'b1;
            2'h2: begin
              if (r.bitn < see_pkg::BITS_BYTE) begin
                next_r.rx = {r.rx[6:0], r.s2};
              end else if (!r.cmd[see_pkg::CMD_READ]) begin
                next_r.nack = r.s2;
              end
            end
            default: begin
              next_r.scl  = 1'b0;
              next_r.bitn = r.bitn + 4'h1;
              if (r.bitn == see_pkg::BITS_BYTE) begin
                next_r.oe = 1'b0;
                if (r.cmd[see_pkg::CMD_STOP]) begin
                  next_r.st = C_STOP;
                end else begin
                  next_r.st   = C_IDLE;
                  next_r.busy = 1'b0;
                end
              end
            end
          endcase
        end
        C_STOP: begin
          case (r.ph)
            2'h0: next_r.oe  = 1'b1;
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.oe  = 1'b0;
            default: begin
              next_r.st   = C_IDLE;
              next_r.busy = 1'b0;
            end
          endcase
        end
        default: next_r.st = C_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.scl     <= 1'b1;
      r.quarter <= see_pkg::QUARTER_RST;
    end else begin
      r <= next_r;
    end
  end

  assign prdata           = r.prdata;
  assign pready           = r.pready;
  assign pslverr          = r.pslverr;
  assign link.scl         = r.scl;
  assign link.ctl_sda_out = 1'b0;
  assign link.ctl_sda_oe  = r.oe;
endmodule

/* see_link_props.sv */
/*
  Link checker: decodes the address byte and watches acknowledges,
  program cycle and data-line driving.
  Assumes tb_top instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module see_link_props #(
  parameter int PROG_CYCLES = see_pkg::PROG_CYCLES
) (
  input wire logic pclk,         // system clock
  input wire logic presetn,      // async reset, active low
  input wire logic scl,          // serial clock
  input wire logic sda,          // resolved data line
  input wire logic dev_sda_oe,   // device pulls data low
  input wire logic wp,           // write protect
  input wire logic cs_level,     // strap level
  input wire logic cs_connected, // strap wired
  input wire logic busy          // program cycle
);
  // ------------------------------------------------------------------
  // address byte decoder
  // ------------------------------------------------------------------
  logic        scl_q, sda_q, first, bsy_st, nomatch;
  logic [3:0]  nb;
  logic [7:0]  sh;
  int unsigned cnt;
  wire         start = scl & scl_q & sda_q & ~sda;
  wire         stop  = scl & scl_q & ~sda_q & sda;
  wire         rise  = scl & ~scl_q;
  wire         ackb  = rise & (nb == 4'h8) & first;
  // floating strap reads low
  wire         match = (sh[7:3] == see_pkg::TYPE_PREFIX) & (sh[2] == (cs_connected & cs_level));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_q, sda_q, first, bsy_st, nomatch, nb, sh, cnt} <= '0;
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      cnt <= busy ? cnt + 1 : 0;
      // busy anywhere in the byte makes the answer uncertain
      bsy_st <= start ? busy : (bsy_st | busy);
      if (start) begin
        {first, nb, nomatch} <= {1'b1, 4'h0, 1'b0};
      end else if (rise) begin
        nb <= (nb == 4'h8) ? 4'h0 : nb + 4'h1;
        if (nb == 4'h8) first <= 1'b0;
        else sh <= {sh[6:0], sda};
        if (ackb && !match) nomatch <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ack_match_a: assert property (ackb && match && !bsy_st |-> !sda)
    else $error("matching address not acknowledged");
  nack_wrong_a: assert property (ackb && !match |-> sda)
    else $error("foreign address acknowledged");
  idle_nomatch_a: assert property (nomatch |-> !dev_sda_oe)
    else $error("device active after foreign address");
  poll_busy_a: assert property (ackb && busy |-> sda)
    else $error("address acknowledged while programming");
  busy_quiet_a: assert property (busy |-> !dev_sda_oe)
    else $error("device drives line while programming");
  wp_block_a: assert property (wp && !busy |=> !busy)
    else $error("program cycle under write protect");
  prog_len_a: assert property ($fell(busy) |-> cnt >= PROG_CYCLES - 1 && cnt <= PROG_CYCLES + 1)
    else $error("program cycle length wrong");
  oe_low_scl_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed with clock high");
  stop_free_a: assert property (stop |-> !dev_sda_oe [*8])
    else $error("device drives line after stop");

  cover property (ackb && match);
  cover property ($fell(busy));
  cover property (stop && !first);
endmodule

/* tb_top.sv */
/*
  Testbench: controller and device joined by the link interface.
  Assumes see_pkg is compiled first; drives APB, strap and protect.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int         PROG = 300;
  localparam logic [4:0] S = 5'h01, P = 5'h02, RD = 5'h04, AK = 5'h08, NB = 5'h10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, strap, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, s;
  logic [16:0] ptr, a;
  logic [7:0]  mem [int];
  logic [3:0]  cases [5];
  int          mismatches, total_checks, cyc;

  see_link_if lnk();
  see_dev #(.PROG_CYCLES(PROG)) i_see_dev(.pclk(pclk), .presetn(presetn), .link(lnk.dev),
    .busy(busy));
  see_ctl i_see_ctl(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk.ctl));
  see_link_props #(.PROG_CYCLES(PROG)) i_see_link_props(.pclk(pclk), .presetn(presetn),
    .scl(lnk.scl), .sda(lnk.sda), .dev_sda_oe(lnk.dev_sda_oe), .wp(lnk.wp),
    .cs_level(lnk.cs_level), .cs_connected(lnk.cs_connected), .busy(busy));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    total_checks++;
    if (v !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d, output logic [31:0] r);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one link command, then wait until the controller is idle
  task automatic xfer(logic [4:0] f, logic [7:0] b, output logic [31:0] r);
    apb(1'b1, see_pkg::REG_CMD, {19'h0, f, b}, r);
    do apb(1'b0, see_pkg::REG_STATUS, 32'h0, r); while (r[see_pkg::ST_BUSY] !== 1'b0);
  endtask

  function automatic logic [7:0] dw(logic pg, logic rw);
    return {see_pkg::TYPE_PREFIX, strap, pg, rw};
  endfunction

  task automatic hdr(logic [16:0] ad);
    logic [31:0] r;
    logic [7:0]  h [3];
    h = '{dw(ad[16], 1'b0), ad[15:8], ad[7:0]};
    for (int k = 0; k < 3; k++) begin
      xfer(k == 0 ? S : 5'h00, h[k], r);
      chk("address ack", 0, r[see_pkg::ST_NACK]);
    end
  endtask

  task automatic wr(logic [16:0] ad, int n);
    logic [31:0] r;
    logic [7:0]  d;
    int          k;
    hdr(ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      xfer(i == n - 1 ? P : 5'h00, d, r);
      chk("data ack", 0, r[see_pkg::ST_NACK]);
      if (!lnk.wp) mem[ad] = d;
      ad[7:0] = ad[7:0] + 8'h01;
    end
    ptr = ad;
    k = 0;
    do begin
      xfer(S, dw(1'b0, 1'b0), r);
      k++;
    end while (r[see_pkg::ST_NACK] && k < 50);
    chk("poll acked", 0, r[see_pkg::ST_NACK]);
    xfer(P | NB, 8'h00, r);
    chk("poll nacked", 32'(!lnk.wp), 32'(k > 1));
  endtask

  task automatic rd(logic [16:0] ad, logic rnd, int n);
    logic [31:0] r;
    if (rnd) begin
      hdr(ad);
      ptr = ad;
    end
    xfer(S, dw(ptr[16], 1'b1), r);
    chk("read ack", 0, r[see_pkg::ST_NACK]);
    for (int i = 0; i < n; i++) begin
      xfer(i == n - 1 ? RD | P : RD | AK, 8'h00, r);
      chk("read byte", mem[ptr], r[15:8]);
      ptr = ptr + 17'h1;
    end
  endtask

  // ------------------------------------------------------------------
  // clock, timeout, sequence
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // about 65k cycles expected; page write dominates
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 100000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {lnk.wp, lnk.cs_level, lnk.cs_connected, strap} = 4'h7;
    {mismatches, total_checks, cyc} = '0;
    cases = '{4'hF, 4'hD, 4'h5, 4'h7, 4'hE};
    void'($urandom(12666));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, see_pkg::REG_DIV, 32'h4, s);
    apb(1'b0, see_pkg::REG_DIV, 32'h0, s);
    chk("divider", 32'h4, s[7:0]);
    apb(1'b0, 8'h0C, 32'h0, s);
    chk("unmapped error", 1, err);
    // strap table: connected, level, sent strap, prefix good
    foreach (cases[c]) begin
      {lnk.cs_connected, lnk.cs_level, strap} <= cases[c][3:1];
      @(posedge pclk);
      xfer(S, dw(1'b0, 1'b0) ^ {~cases[c][0], 7'h00}, s);
      chk("strap ack", 32'(!(cases[c][0] && cases[c][1] == (cases[c][3] & cases[c][2]))),
          32'(s[see_pkg::ST_NACK]));
      xfer(P | NB, 8'h00, s);
    end
    repeat (3) begin
      a = 17'($urandom);
      wr(a, 1);
      rd(a, 1'b1, 1);
    end
    a = {9'($urandom), 8'hFD};
    wr(a, 258);
    rd({a[16:8], 8'hFD}, 1'b1, 3);
    rd({a[16:8], 8'h00}, 1'b1, 2);
    wr(17'h1FFFE, 2);
    wr(17'h00000, 2);
    rd(17'h1FFFE, 1'b1, 3);
    rd(17'h00000, 1'b0, 1);
    lnk.wp <= 1'b1;
    wr(17'h1FFFE, 1);
    lnk.wp <= 1'b0;
    rd(17'h1FFFE, 1'b1, 1);
    finish_test();
  end
endmodule
